// *** design/smc_map.svh ***
// register indices, field positions, reset values and timing counts
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// register indices; byte address is four times the index
`define SMC_IDX_L2_STATUS 8'h31
`define SMC_IDX_DET_EN 8'h32
`define SMC_IDX_MON0_CTL 8'h38
`define SMC_IDX_IRQ_STATUS 8'h3A
`define SMC_IDX_IRQ_MASK 8'h3B
`define SMC_IDX_PROTECT 8'h3E

// detector enable register fields
`define SMC_DET_LOW_POWER_BIT 0
`define SMC_DET0_EN_BIT 5
`define SMC_DET_WR_MASK 8'hE1

// level-2 status register field
`define SMC_L2_FLAG_BIT 3

// monitor-0 control fields
`define SMC_MON0_RST_EN_BIT 0
`define SMC_MON0_BYPASS_BIT 1
`define SMC_MON0_DIV_LO 4
`define SMC_MON0_WR_MASK 8'hF7

// protection register field
`define SMC_PROT_UNLOCK_BIT 3

// reset values
`define SMC_DET_EN_RST_POR 8'h20
`define SMC_DET_EN_RST_HW_OPT 8'h00
`define SMC_MON0_RST_POR 8'hC3
`define SMC_MON0_RST_HW_OPT 8'h82

// timing
`define SMC_CLK_PERIOD_NS 32'd4
`define SMC_SETTLE_DELAY_NS 32'd100000
`define SMC_SETTLE_CYCLES \
	((`SMC_SETTLE_DELAY_NS + `SMC_CLK_PERIOD_NS - 32'd1) / `SMC_CLK_PERIOD_NS)

`endif

// *** design/smc_pkg.sv ***
// shared types of the supply monitor control block
package smc_pkg;
	typedef logic [7:0] smc_reg8_t;
	typedef logic [3:0] smc_irq_vec_t;
	typedef logic [2:0] smc_det_vec_t;
endpackage

// *** design/smc_det_if.sv ***
// carrier between the control logic and one detector settle timer
`timescale 1ns/10ps
interface smc_det_if;
	logic en;
	logic ready;
	logic done;
	modport timer (input en, output ready, output done);
	modport ctl (output en, input ready, input done);
endinterface

// *** design/smc_sync.sv ***
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
module smc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// level in and out
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_ff;

	// first stage is read only by the second
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_ff <= '0;
			o_sync <= '0;
		end else begin
			meta_ff <= i_async;
			o_sync <= meta_ff;
		end
	end
endmodule

// *** design/smc_settle.sv ***
// settle timer: holds a detector idle after its enable rises
`timescale 1ns/10ps
module smc_settle #(
	parameter int unsigned SETTLE_CYCLES = 1
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// link to the control logic
	smc_det_if.timer det
);
	logic [15:0] cnt_ff;

	// count enabled cycles; dropping the enable restarts the wait
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff <= 16'h0000;
			det.ready <= 1'b0;
			det.done <= 1'b0;
		end else if (!det.en) begin
			cnt_ff <= 16'h0000;
			det.ready <= 1'b0;
			det.done <= 1'b0;
		end else if (!det.ready) begin
			cnt_ff <= cnt_ff + 16'h0001;
			det.ready <= (cnt_ff == 16'(SETTLE_CYCLES - 1));
			det.done <= (cnt_ff == 16'(SETTLE_CYCLES - 1));
		end else begin
			det.done <= 1'b0;
		end
	end
endmodule

// *** design/smc_top.sv ***
// supply monitor control registers with avalon-mm slave
//
// How it works
// - level-2 flag follows the comparator only while detector 2 is enabled
// - with detector 2 disabled the level-2 flag reads 1
// - software, watchdog and monitor-1/2 resets leave both registers alone
// - detector enable resets 00h on strap hw reset, else 20h
// - low-power bit: 0 off, 1 on; meant only for wait entry
// - three detector enable bits; reserved bits 4..1 stay zero
// - a detector starts only after settle delay following its enable
// - monitor-0 control resets 82h on strap hw reset, else C3h
// - monitor-0 reset enable: 0 disables, 1 enables
// - monitor-0 filter bit: 0 filter on, 1 filter bypassed
// - level-2 flag is read only: 0 below once settled, 1 at/above, unsettled or disabled
// - sampling select bits 5:4 divide the slow clock by 1,2,4,8
`timescale 1ns/10ps
`include "smc_map.svh"
module smc_top #(
	parameter int unsigned SETTLE_CYCLES = `SMC_SETTLE_CYCLES
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// avalon-mm slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// reset sources and strap
	input wire logic i_hw_reset_req,
	input wire logic i_mon0_reset_req,
	input wire logic i_boot_detector0_option,
	// analog comparator result
	input wire logic i_level2_above,
	// detector controls
	output logic [2:0] o_detector_enable,
	output logic [2:0] o_detector_active,
	output logic o_internal_low_power_enable,
	output logic o_monitor0_reset_enable,
	output logic o_monitor0_filter_bypass,
	output logic [1:0] o_monitor0_sample_div,
	// interrupt
	output logic o_irq
);
	smc_pkg::smc_reg8_t det_en_ff;
	smc_pkg::smc_reg8_t mon0_ctl_ff;
	smc_pkg::smc_irq_vec_t irq_status_ff;
	smc_pkg::smc_irq_vec_t irq_mask_ff;
	smc_pkg::smc_det_vec_t det_done;
	smc_pkg::smc_det_vec_t det_ready;
	logic unlock_ff;
	logic l2_flag_ff;
	logic nxt_l2_flag;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic irq_ff;
	logic [2:0] sync_s;
	logic cmp2_s;
	logic hw_rst_s;
	logic mon0_rst_s;
	logic req;
	logic wr_go;
	logic rd_go;
	logic [7:0] idx;
	logic wr_det;
	logic wr_mon0;
	logic l2_fall;
	logic [31:0] nxt_rdata;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers

	// pins and analog levels are asynchronous to the register clock
	smc_sync #(
		.W(3)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_level2_above, i_hw_reset_req, i_mon0_reset_req}),
		.o_sync(sync_s)
	);
	assign cmp2_s = sync_s[2];
	assign hw_rst_s = sync_s[1];
	assign mon0_rst_s = sync_s[0];

	////////////////////////////////////////////////////////////////////////
	// bus decode

	// one wait cycle, then the request is taken on waitrequest low
	assign req = i_avs_read | i_avs_write;
	assign wr_go = i_avs_write & ~wait_ff;
	assign rd_go = i_avs_read & ~wait_ff;
	assign idx = {2'b00, i_avs_address[7:2]};
	assign wr_det = wr_go & i_avs_byteenable[0] & (idx == `SMC_IDX_DET_EN);
	assign wr_mon0 = wr_go & i_avs_byteenable[0]
		& (idx == `SMC_IDX_MON0_CTL);

	// waitrequest drops for one cycle per request
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_ff <= 1'b1;
		end else begin
			wait_ff <= ~(req & wait_ff);
		end
	end

	// read mux; unmapped indices and reserved bits read zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (idx)
			`SMC_IDX_L2_STATUS: nxt_rdata[`SMC_L2_FLAG_BIT] = l2_flag_ff;
			`SMC_IDX_DET_EN: nxt_rdata[7:0] = det_en_ff;
			`SMC_IDX_MON0_CTL: nxt_rdata[7:0] = mon0_ctl_ff;
			`SMC_IDX_IRQ_STATUS: nxt_rdata[3:0] = irq_status_ff;
			`SMC_IDX_IRQ_MASK: nxt_rdata[3:0] = irq_mask_ff;
			`SMC_IDX_PROTECT: nxt_rdata[`SMC_PROT_UNLOCK_BIT] = unlock_ff;
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// read data registered as waitrequest drops, stands with it
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (i_avs_read & wait_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// protection register

	// unlock bit gates both protected registers
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			unlock_ff <= 1'b0;
		end else if (wr_go & i_avs_byteenable[0]
			& (idx == `SMC_IDX_PROTECT)) begin
			unlock_ff <= i_avs_writedata[`SMC_PROT_UNLOCK_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// detector enable register

	// only power-on, monitor-0 and hw resets reach this register
	// survives other resets
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			det_en_ff <= `SMC_DET_EN_RST_POR;
		end else if (mon0_rst_s) begin
			det_en_ff <= `SMC_DET_EN_RST_POR;
		end else if (hw_rst_s) begin
			det_en_ff <= i_boot_detector0_option ? `SMC_DET_EN_RST_HW_OPT
				: `SMC_DET_EN_RST_POR;
		end else if (wr_det & unlock_ff) begin
			det_en_ff <= i_avs_writedata[7:0] & `SMC_DET_WR_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// monitor-0 control register

	// bit 3 is not stored; it reads zero
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mon0_ctl_ff <= `SMC_MON0_RST_POR;
		end else if (mon0_rst_s) begin
			mon0_ctl_ff <= `SMC_MON0_RST_POR;
		end else if (hw_rst_s) begin
			mon0_ctl_ff <= i_boot_detector0_option ? `SMC_MON0_RST_HW_OPT
				: `SMC_MON0_RST_POR;
		end else if (wr_mon0 & unlock_ff) begin
			mon0_ctl_ff <= i_avs_writedata[7:0] & `SMC_MON0_WR_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// settle timers, one per detector

	generate
		for (genvar g = 0; g < 3; g++) begin : g_det
			smc_det_if u_if ();
			assign u_if.en = det_en_ff[`SMC_DET0_EN_BIT + g];
			assign det_ready[g] = u_if.ready;
			assign det_done[g] = u_if.done;
			smc_settle #(
				.SETTLE_CYCLES(SETTLE_CYCLES)
			) u_settle (
				.i_ref_clk(i_ref_clk),
				.i_rst_n(i_rst_n),
				.det(u_if.timer)
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// level-2 supply flag

	// unsettled comparator output is not trusted, so it reads 1 meanwhile
	// follow comparator when active
	// disabled detector reads 1
	// the timer sees the enable drop one edge late, so gate on both
	assign nxt_l2_flag = (det_ready[2] & det_en_ff[7]) ? cmp2_s : 1'b1;
	assign l2_fall = l2_flag_ff & ~nxt_l2_flag;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			l2_flag_ff <= 1'b1;
		end else begin
			l2_flag_ff <= nxt_l2_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status and mask

	// only bits that the read reported are cleared, so an event
	// landing while the read waits is never lost; set wins the clear
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_status_ff <= 4'h0;
		end else if (rd_go & (idx == `SMC_IDX_IRQ_STATUS)) begin
			irq_status_ff <= (irq_status_ff & ~rdata_ff[3:0])
				| {l2_fall, det_done};
		end else begin
			irq_status_ff <= irq_status_ff | {l2_fall, det_done};
		end
	end

	// mask register, same layout as status
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_mask_ff <= 4'h0;
		end else if (wr_go & i_avs_byteenable[0]
			& (idx == `SMC_IDX_IRQ_MASK)) begin
			irq_mask_ff <= i_avs_writedata[3:0];
		end
	end

	// level output, one cycle behind status
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_status_ff & irq_mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all from flops

	assign o_avs_readdata = rdata_ff;
	assign o_avs_waitrequest = wait_ff;
	assign o_irq = irq_ff;
	assign o_detector_enable = det_en_ff[7:5];
	assign o_detector_active = det_ready;
	assign o_internal_low_power_enable = det_en_ff[`SMC_DET_LOW_POWER_BIT];
	assign o_monitor0_reset_enable = mon0_ctl_ff[`SMC_MON0_RST_EN_BIT];
	assign o_monitor0_filter_bypass = mon0_ctl_ff[`SMC_MON0_BYPASS_BIT];
	assign o_monitor0_sample_div =
		mon0_ctl_ff[`SMC_MON0_DIV_LO + 1:`SMC_MON0_DIV_LO];

	////////////////////////////////////////////////////////////////////////
	// checks

	logic [15:0] det0_age_ff;

	// cycles since detector 0 was enabled, saturating
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			det0_age_ff <= 16'h0000;
		end else if (!det_en_ff[`SMC_DET0_EN_BIT]) begin
			det0_age_ff <= 16'h0000;
		end else if (det0_age_ff != 16'hFFFF) begin
			det0_age_ff <= det0_age_ff + 16'h0001;
		end
	end

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	chk_l2_tracks_cmp: assert property (
		det_ready[2] && det_en_ff[7] |=> l2_flag_ff == $past(cmp2_s)
	) else $error("level-2 flag does not follow comparator");

	chk_l2_disabled_high: assert property (
		!det_en_ff[7] |=> l2_flag_ff
	) else $error("level-2 flag low while detector 2 disabled");

	chk_det_hw_reset: assert property (
		hw_rst_s && !mon0_rst_s |=> det_en_ff ==
			($past(i_boot_detector0_option) ? 8'h00 : 8'h20)
	) else $error("detector enable wrong after hw reset");

	chk_reserved_zero: assert property (
		det_en_ff[4:1] == 4'h0
	) else $error("reserved detector bits not zero");

	chk_settle_wait: assert property (
		det_ready[0] |-> det0_age_ff >= 16'(SETTLE_CYCLES)
	) else $error("detector 0 active before settle delay");

	chk_mon0_reset_val: assert property (
		mon0_rst_s |=> mon0_ctl_ff == 8'hC3 && det_en_ff == 8'h20
	) else $error("monitor-0 reset values wrong");

	chk_reset_en_write: assert property (
		wr_mon0 && unlock_ff && !hw_rst_s && !mon0_rst_s
		|=> o_monitor0_reset_enable == $past(i_avs_writedata[0])
	) else $error("monitor-0 reset enable not written");

	chk_bypass_write: assert property (
		wr_mon0 && unlock_ff && !hw_rst_s && !mon0_rst_s
		|=> o_monitor0_filter_bypass == $past(i_avs_writedata[1])
	) else $error("filter bypass bit not written");

	chk_l2_read_value: assert property (
		i_avs_read && wait_ff && idx == `SMC_IDX_L2_STATUS
		|=> o_avs_readdata == {28'h0000_000, $past(l2_flag_ff), 3'b000}
	) else $error("level-2 status read wrong");

	chk_locked_write: assert property (
		wr_det && !unlock_ff && !hw_rst_s && !mon0_rst_s
		|=> $stable(det_en_ff)
	) else $error("detector enable changed while locked");

	chk_irq_level: assert property (
		(irq_status_ff & irq_mask_ff) != 4'h0 |=> o_irq
	) else $error("interrupt not raised");

	cov_det2_active: cover property (
		det_en_ff[7] ##1 $rose(det_ready[2])
	);
	cov_hw_reset_opt: cover property (
		hw_rst_s && i_boot_detector0_option
	);
	cov_locked_write: cover property (wr_det && !unlock_ff);
	cov_irq: cover property ($rose(o_irq));
endmodule

// *** tb/smc_top_test.sv ***
// self-checking bench for the supply monitor control registers
`timescale 1ns/10ps
`include "smc_map.svh"
module smc_top_test;
	localparam int SETTLE = 12;
	localparam int LIMIT = 20000;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'h1;
	logic hw_req = 1'b0;
	logic mon0_req = 1'b0;
	logic boot_opt = 1'b0;
	logic level2_above = 1'b1;
	logic [31:0] readdata;
	logic waitrequest;
	logic [2:0] det_en;
	logic [2:0] det_act;
	logic low_power;
	logic mon0_rst_en;
	logic mon0_bypass;
	logic [1:0] mon0_div;
	logic irq;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	// behavioural copies of the two reset-sensitive registers
	logic [7:0] m_det;
	logic [7:0] m_mon;

	smc_top #(.SETTLE_CYCLES(SETTLE)) u_smc_top (
		.i_ref_clk(ref_clk),
		.i_rst_n(rst_n),
		.i_avs_address(avs_address),
		.i_avs_read(avs_read),
		.i_avs_write(avs_write),
		.i_avs_writedata(avs_writedata),
		.i_avs_byteenable(avs_byteenable),
		.o_avs_readdata(readdata),
		.o_avs_waitrequest(waitrequest),
		.i_hw_reset_req(hw_req),
		.i_mon0_reset_req(mon0_req),
		.i_boot_detector0_option(boot_opt),
		.i_level2_above(level2_above),
		.o_detector_enable(det_en),
		.o_detector_active(det_act),
		.o_internal_low_power_enable(low_power),
		.o_monitor0_reset_enable(mon0_rst_en),
		.o_monitor0_filter_bypass(mon0_bypass),
		.o_monitor0_sample_div(mon0_div),
		.o_irq(irq)
	);

	////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #2 ref_clk = ~ref_clk;

	// a stuck handshake must not hold the run forever
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_count++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic chk(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one avalon-mm cycle; request held until waitrequest sampled low
	task automatic bus(input bit wr, input logic [7:0] idx,
			input logic [7:0] wd, output logic [31:0] rd);
		@(posedge ref_clk);
		avs_address <= {idx[5:0], 2'b00};
		avs_writedata <= {24'h00_0000, wd};
		avs_write <= wr;
		avs_read <= ~wr;
		// only the bench timeout may end this wait
		do begin
			@(posedge ref_clk);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] idx,
			input logic [7:0] exp);
		logic [31:0] rd;
		bus(1'b0, idx, 8'h00, rd);
		chk(name, rd, {24'h00_0000, exp});
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] rd;
		bus(1'b1, idx, wd, rd);
	endtask

	// pulse one reset source for a few cycles, then let it settle
	task automatic pulse_reset(input bit hw, input bit opt);
		@(posedge ref_clk);
		boot_opt <= opt;
		hw_req <= hw;
		mon0_req <= ~hw;
		repeat (5) @(posedge ref_clk);
		hw_req <= 1'b0;
		mon0_req <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic outs_chk();
		#1;
		chk("det_en", det_en, m_det[7:5]);
		chk("low_power", low_power, m_det[0]);
		chk("mon0_rst_en", mon0_rst_en, m_mon[0]);
		chk("mon0_bypass", mon0_bypass, m_mon[1]);
		chk("mon0_div", mon0_div, m_mon[5:4]);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [7:0] wd;
		logic [31:0] rd;
		int n;
		void'($urandom(86));
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		m_det = `SMC_DET_EN_RST_POR;
		m_mon = `SMC_MON0_RST_POR & 8'hF7;
		// power-on values
		rd_chk("det reset", `SMC_IDX_DET_EN, m_det);
		rd_chk("mon0 reset", `SMC_IDX_MON0_CTL, m_mon);
		rd_chk("l2 reset", `SMC_IDX_L2_STATUS, 8'h08);
		rd_chk("unmapped", 8'h10, 8'h00);
		outs_chk();
		// locked writes are dropped
		wr(`SMC_IDX_DET_EN, 8'h41);
		rd_chk("det locked", `SMC_IDX_DET_EN, m_det);
		// unlocked random writes; reserved bits stay zero
		// unlock before rewrite
		wr(`SMC_IDX_PROTECT, 8'h08);
		// no stop request: the bench has no such strobe
		// detector 1 toggled here; no level-1 use
		for (int i = 0; i < 6; i++) begin
			wd = 8'($urandom);
			wr(`SMC_IDX_DET_EN, wd);
			m_det = wd & `SMC_DET_WR_MASK;
			rd_chk("det rw", `SMC_IDX_DET_EN, m_det);
			wd = {8'($urandom)} & 8'hCF | 8'(i % 4 << 4);
			wr(`SMC_IDX_MON0_CTL, wd);
			m_mon = wd & `SMC_MON0_WR_MASK;
			rd_chk("mon0 rw", `SMC_IDX_MON0_CTL, m_mon);
			outs_chk();
		end
		// lane 0 disabled: nothing changes
		avs_byteenable <= 4'h0;
		wr(`SMC_IDX_DET_EN, ~m_det);
		avs_byteenable <= 4'h1;
		rd_chk("det no lane", `SMC_IDX_DET_EN, m_det);
		// detector 2 off, comparator low: flag still reads 1
		level2_above <= 1'b0;
		wr(`SMC_IDX_DET_EN, 8'h00);
		repeat (SETTLE + 6) @(posedge ref_clk);
		rd_chk("l2 off", `SMC_IDX_L2_STATUS, 8'h08);
		bus(1'b0, `SMC_IDX_IRQ_STATUS, 8'h00, rd);
		// enable detector 2 and time its settle
		// detector 2 on first
		wr(`SMC_IDX_DET_EN, 8'h80);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (det_act[2] !== 1'b1 && n < 60);
		chk("settle", n >= SETTLE && n <= SETTLE + 2, 1'b1);
		repeat (5) @(posedge ref_clk);
		rd_chk("l2 low", `SMC_IDX_L2_STATUS, 8'h00);
		// mask settle and fall events, then read-clear
		wr(`SMC_IDX_IRQ_MASK, 8'h0C);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("irq on", irq, 1'b1);
		rd_chk("irq status", `SMC_IDX_IRQ_STATUS, 8'h0C);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("irq off", irq, 1'b0);
		level2_above <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rd_chk("l2 high", `SMC_IDX_L2_STATUS, 8'h08);
		// hw reset with each strap value, monitor-0 reset with strap 1
		pulse_reset(1'b1, 1'b1);
		m_det = `SMC_DET_EN_RST_HW_OPT;
		m_mon = `SMC_MON0_RST_HW_OPT;
		rd_chk("det hw opt", `SMC_IDX_DET_EN, m_det);
		rd_chk("mon0 hw opt", `SMC_IDX_MON0_CTL, m_mon);
		outs_chk();
		// detector 0 on before monitor-0 reset
		wr(`SMC_IDX_DET_EN, 8'h20);
		pulse_reset(1'b0, 1'b1);
		m_det = `SMC_DET_EN_RST_POR;
		m_mon = `SMC_MON0_RST_POR & 8'hF7;
		rd_chk("det mon0", `SMC_IDX_DET_EN, m_det);
		rd_chk("mon0 mon0", `SMC_IDX_MON0_CTL, m_mon);
		pulse_reset(1'b1, 1'b1);
		pulse_reset(1'b1, 1'b0);
		rd_chk("det hw", `SMC_IDX_DET_EN, m_det);
		rd_chk("mon0 hw", `SMC_IDX_MON0_CTL, m_mon);
		outs_chk();
		tally_and_finish();
	end
endmodule
